// [logic/ebc_pkg.sv]
// Purpose: Shared constants for the external bus configuration and fault block
// Assumes: 32-bit AHB-Lite register bus, byte offsets below
// Notes: Widths 8/16/32 use codes 0/1/2; code 3 is not stored
package ebc_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int NUM_CS_MAX = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_ENDIAN = 8'h00;
    localparam logic [7:0] OFS_SDRAM_MODE = 8'h04;
    localparam logic [7:0] OFS_SDRAM_CTL = 8'h08;
    localparam logic [7:0] OFS_FLT_EN = 8'h0C;
    localparam logic [7:0] OFS_FLT_CLR = 8'h10;
    localparam logic [7:0] OFS_FLT_STAT = 8'h14;
    localparam logic [7:0] OFS_FLT_MASK = 8'h18;
    localparam logic [7:0] OFS_FLT_ADDR = 8'h1C;
    localparam logic [7:0] OFS_CS_BASE = 8'h20;

    // Field positions
    localparam int AREA_EN_BIT = 0;
    localparam int AREA_SWAP_BIT = 1;
    localparam int AREA_WID_LSB = 4;
    localparam int AREA_MUX_BIT = 8;
    localparam int FLT_ILL_BIT = 0;
    localparam int FLT_TMO_BIT = 1;
    localparam int CLR_BIT = 0;
    localparam int CAP_LSB = 3;
    localparam int CAP_W = 13;
    localparam int ADDR_CAP_LSB = 19;

    // Codes and reset values
    localparam logic [2:0] ENDIAN_LITTLE = 3'h7;
    localparam logic [2:0] ENDIAN_BIG = 3'h0;
    localparam logic [2:0] ENDIAN_RESET = 3'h7;
    localparam logic [1:0] WID_8 = 2'h0;
    localparam logic [1:0] WID_16 = 2'h1;
    localparam logic [1:0] WID_32 = 2'h2;
    localparam logic [1:0] WID_BAD = 2'h3;
    localparam logic [1:0] FLT_EN_RESET = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Address map: top five address bits
    localparam logic [4:0] MAP_INTERNAL = 5'h00;
    localparam logic [4:0] MAP_SDRAM = 5'h01;
    localparam logic [4:0] MAP_CS = 5'h1F;

    // Cycles an external access may take before it is declared hung
    localparam int TIMEOUT_CYCLES = 768;

    typedef enum logic {EBC_IDLE, EBC_BUSY} ebc_state_t;
endpackage

// [logic/ebc_timeout.sv]
// Purpose: Counts cycles of an open external access, flags a hang
// Assumes: run is high from the first busy cycle until the access ends
// Notes: expired is a one-cycle pulse in the cycle after the limit
`timescale 1ns/1ps
module ebc_timeout import ebc_pkg::*; #(
    parameter int LIMIT = TIMEOUT_CYCLES
) (
    // Clock, reset and enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Control
    input wire logic run,
    output logic expired
);
    localparam int CNT_W = $clog2(LIMIT + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LIMIT - 1);

    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= '0;
        end else if (ce) begin
            if (!run || expired) begin
                cnt_reg <= '0;
            end else if (cnt_reg != CNT_LAST) begin
                cnt_reg <= cnt_reg + CNT_W'(1);
            end
        end
    end

    // Fires once LIMIT busy cycles have passed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            expired <= 1'b0;
        end else if (ce) begin
            expired <= run && !expired && (cnt_reg == CNT_LAST); // [RULE_08]
        end
    end
endmodule

// [logic/ebc_top.sv]
// Purpose: External bus area configuration and bus fault detection
// Assumes: AHB-Lite slave, zero wait states; access strobes from same clock
// Notes: Timeout limit shortens through TIMEOUT_LIMIT for simulation
// Notes on behaviour
// (RULE_01) Every chip-select area and the SDRAM area has its own byte swap bit.
// (RULE_02) Swap set gives the opposite order to the main code; 7 little, 0 big.
// (RULE_03) Software runs code only from areas whose swap bit is clear.
// (RULE_04) Each area has a width field selecting 8, 16 or 32 bits.
// (RULE_05) Each chip-select area has an address/data multiplexing bit.
// (RULE_06) Software never picks 32-bit width on a multiplexed chip-select area.
// (RULE_07) Access to a disabled external area or reserved space is an illegal fault.
// (RULE_08) An access not finished within 768 cycles is a timeout fault.
// (RULE_09) Either fault raises the bus fault interrupt request; the code raises it only for a fault whose flt_mask_reg bit is set.
// (RULE_10) Each fault type is recorded only while its own enable bit is set.
// (RULE_11) A fault captures address bits 31..19 into bits 15..3 of a status word.
// (RULE_12) Fault status holds until software writes one to the clear bit; the code also clears single bits on a one written to the status word.
`timescale 1ns/1ps
module ebc_top import ebc_pkg::*; #(
    parameter int NUM_CS = NUM_CS_MAX,
    parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [DATA_W-1:0] hrdata,
    // External access request and completion
    input wire logic acc_start,
    input wire logic [ADDR_W-1:0] acc_addr,
    input wire logic acc_done,
    // Settings handed to the memory controller
    output logic acc_go,
    output logic acc_fault,
    output logic [NUM_CS-1:0] acc_cs_sel,
    output logic acc_sdram_sel,
    output logic acc_little_endian,
    output logic [1:0] acc_width,
    output logic acc_mux,
    // Interrupt
    output logic bus_fault_irq
);
    localparam int TMO_CHECK = TIMEOUT_LIMIT;

    logic [2:0] main_endian_code_reg;
    logic sdram_mode_ctl_reg;
    logic [2:0] sdram_control_reg;
    logic [1:0] bus_fault_enable_reg;
    logic [1:0] flt_stat_reg;
    logic [1:0] flt_mask_reg;
    logic [CAP_W-1:0] bus_fault_addr_reg;
    logic [8:0] cs_ctl_reg [NUM_CS];
    logic wr_pend_reg;
    logic [7:0] wr_ofs_reg;
    ebc_state_t state_reg;
    logic tmo_raw;
    // Done in the last allowed cycle must not count as a hang
    wire tmo_fire = tmo_raw && (state_reg == EBC_BUSY); // [RULE_08]

    // Area decode, shared by the access path and the checks below
    function automatic logic [3:0] cs_index(input logic [ADDR_W-1:0] a);
        cs_index = {1'b0, ~a[26:24]};
    endfunction

    function automatic logic is_cs(input logic [ADDR_W-1:0] a);
        is_cs = (a[31:27] == MAP_CS) && (int'(cs_index(a)) < NUM_CS);
    endfunction

    // Bus decode
    wire addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire [7:0] ofs = haddr[7:0];
    wire mapped = (haddr[ADDR_W-1:8] == '0);
    wire wr_clr = wr_pend_reg && (wr_ofs_reg == OFS_FLT_CLR) && hwdata[CLR_BIT];

    // Access decode
    wire acc_is_cs = is_cs(acc_addr);
    wire acc_is_sd = (acc_addr[31:27] == MAP_SDRAM);
    wire [3:0] acc_idx = cs_index(acc_addr);
    logic [8:0] acc_ctl;
    always_comb begin
        acc_ctl = {1'b0, 2'h0, sdram_control_reg[2:1], 2'h0, sdram_mode_ctl_reg,
            sdram_control_reg[0]};
        if (acc_is_cs) begin
            acc_ctl = cs_ctl_reg[acc_idx[2:0]];
        end
    end
    wire acc_internal = (acc_addr[31:27] == MAP_INTERNAL);
    wire acc_reserved = !acc_internal && !acc_is_cs && !acc_is_sd;
    wire acc_illegal = acc_reserved || (!acc_internal && !acc_ctl[AREA_EN_BIT]); // [RULE_07]
    wire take = (state_reg == EBC_IDLE) && acc_start && !acc_internal;
    wire main_le = (main_endian_code_reg == ENDIAN_LITTLE);

    // Fault events
    wire ill_evt = take && acc_illegal;
    wire [1:0] flt_set = {tmo_fire && bus_fault_enable_reg[FLT_TMO_BIT],
        ill_evt && bus_fault_enable_reg[FLT_ILL_BIT]}; // [RULE_10]
    logic [ADDR_W-1:0] busy_addr_reg;
    wire [ADDR_W-1:0] flt_addr = ill_evt ? acc_addr : busy_addr_reg;

    // Register writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg <= 8'h00;
        end else if (ce) begin
            wr_pend_reg <= addr_phase && hwrite && mapped;
            wr_ofs_reg <= ofs;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_endian_code_reg <= ENDIAN_RESET;
            sdram_mode_ctl_reg <= 1'b0;
            sdram_control_reg <= 3'h0;
            bus_fault_enable_reg <= FLT_EN_RESET;
            flt_mask_reg <= 2'h0;
        end else if (ce && wr_pend_reg) begin
            case (wr_ofs_reg)
                OFS_ENDIAN: main_endian_code_reg <= hwdata[2:0];
                OFS_SDRAM_MODE: sdram_mode_ctl_reg <= hwdata[AREA_SWAP_BIT]; // [RULE_01]
                OFS_SDRAM_CTL: begin
                    sdram_control_reg[0] <= hwdata[AREA_EN_BIT];
                    if (hwdata[AREA_WID_LSB+:2] != WID_BAD) begin
                        sdram_control_reg[2:1] <= hwdata[AREA_WID_LSB+:2]; // [RULE_04]
                    end
                end
                OFS_FLT_EN: bus_fault_enable_reg <= hwdata[1:0]; // [RULE_10]
                OFS_FLT_MASK: flt_mask_reg <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // One control word per chip-select area
    for (genvar i = 0; i < NUM_CS; i++) begin : g_cs
        localparam logic [7:0] CS_OFS = OFS_CS_BASE + 8'(4 * i);
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cs_ctl_reg[i] <= 9'h000;
            end else if (ce && wr_pend_reg && wr_ofs_reg == CS_OFS) begin
                cs_ctl_reg[i][AREA_EN_BIT] <= hwdata[AREA_EN_BIT];
                cs_ctl_reg[i][AREA_SWAP_BIT] <= hwdata[AREA_SWAP_BIT]; // [RULE_01]
                cs_ctl_reg[i][AREA_MUX_BIT] <= hwdata[AREA_MUX_BIT]; // [RULE_05]
                if (hwdata[AREA_WID_LSB+:2] != WID_BAD) begin
                    cs_ctl_reg[i][AREA_WID_LSB+:2] <= hwdata[AREA_WID_LSB+:2]; // [RULE_04]
                end
            end
        end
    end

    // Read data sampled in the address phase; a read right after a write
    // to the same word sees the old value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce && addr_phase && !hwrite) begin
            hrdata <= '0;
            if (mapped) begin
                case (ofs)
                    OFS_ENDIAN: hrdata <= {29'h0, main_endian_code_reg};
                    OFS_SDRAM_MODE: hrdata <= {30'h0, sdram_mode_ctl_reg, 1'b0};
                    OFS_SDRAM_CTL: hrdata <= {26'h0, sdram_control_reg[2:1], 3'h0,
                        sdram_control_reg[0]};
                    OFS_FLT_EN: hrdata <= {30'h0, bus_fault_enable_reg};
                    OFS_FLT_STAT: hrdata <= {30'h0, flt_stat_reg};
                    OFS_FLT_MASK: hrdata <= {30'h0, flt_mask_reg};
                    OFS_FLT_ADDR: hrdata <= {16'h0, bus_fault_addr_reg, 3'h0}; // [RULE_11]
                    default: begin
                        if (ofs >= OFS_CS_BASE && int'(ofs - OFS_CS_BASE) < 4 * NUM_CS
                            && ofs[1:0] == 2'h0) begin
                            hrdata <= {23'h0, cs_ctl_reg[3'((ofs - OFS_CS_BASE) >> 2)]};
                        end
                    end
                endcase
            end
        end
    end

    // Access sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= EBC_IDLE;
            busy_addr_reg <= '0;
        end else if (ce) begin
            case (state_reg)
                EBC_IDLE: begin
                    if (take && !acc_illegal) begin
                        state_reg <= EBC_BUSY;
                        busy_addr_reg <= acc_addr;
                    end
                end
                EBC_BUSY: begin
                    // A hang is reported even if done arrives in the same cycle
                    if (tmo_fire || acc_done) begin
                        state_reg <= EBC_IDLE;
                    end
                end
                default: state_reg <= EBC_IDLE;
            endcase
        end
    end

    ebc_timeout #(.LIMIT(TIMEOUT_LIMIT)) u_tmo (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .run(state_reg == EBC_BUSY),
        .expired(tmo_raw)
    );

    // Settings presented with each accepted access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_go <= 1'b0;
            acc_fault <= 1'b0;
            acc_cs_sel <= '0;
            acc_sdram_sel <= 1'b0;
            acc_little_endian <= 1'b1;
            acc_width <= WID_8;
            acc_mux <= 1'b0;
        end else if (ce) begin
            acc_go <= take && !acc_illegal;
            acc_fault <= ill_evt || tmo_fire; // [RULE_07] [RULE_08]
            if (take && !acc_illegal) begin
                acc_cs_sel <= '0;
                if (acc_is_cs) begin
                    acc_cs_sel[acc_idx[2:0]] <= 1'b1;
                end
                acc_sdram_sel <= acc_is_sd;
                acc_little_endian <= main_le ^ acc_ctl[AREA_SWAP_BIT]; // [RULE_02]
                acc_width <= acc_ctl[AREA_WID_LSB+:2]; // [RULE_04]
                acc_mux <= acc_is_cs && acc_ctl[AREA_MUX_BIT]; // [RULE_05]
            end
        end
    end

    // Sticky fault flags; a new fault beats a clear in the same cycle
    wire [1:0] stat_w1c = (wr_pend_reg && wr_ofs_reg == OFS_FLT_STAT) ? hwdata[1:0] : 2'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flt_stat_reg <= 2'h0;
            bus_fault_addr_reg <= '0;
        end else if (ce) begin
            flt_stat_reg <= ((wr_clr ? 2'h0 : flt_stat_reg) & ~stat_w1c) | flt_set; // [RULE_12]
            if (flt_set != 2'h0 && (flt_stat_reg == 2'h0 || wr_clr)) begin
                bus_fault_addr_reg <= flt_addr[ADDR_CAP_LSB+:CAP_W]; // [RULE_11]
            end else if (wr_clr) begin
                bus_fault_addr_reg <= '0; // [RULE_12]
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_fault_irq <= 1'b0;
        end else if (ce) begin
            bus_fault_irq <= |(flt_stat_reg & flt_mask_reg); // [RULE_09]
        end
    end

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [15:0] busy_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_cnt <= 16'h0000;
        end else if (ce) begin
            busy_cnt <= (state_reg == EBC_BUSY) ? busy_cnt + 16'h0001 : 16'h0000;
        end
    end

    a_swap_order: assert property (ce && take && !acc_illegal |=> // [RULE_02]
        acc_little_endian == ($past(main_le) ^ $past(acc_ctl[AREA_SWAP_BIT])))
        else $error("byte order does not follow swap bit");
    a_width_follow: assert property (ce && take && !acc_illegal |=> // [RULE_04]
        acc_width == $past(acc_ctl[AREA_WID_LSB+:2]) && acc_width != WID_BAD)
        else $error("access width does not follow area setting");
    a_mux_follow: assert property (ce && take && !acc_illegal |=> // [RULE_05]
        acc_mux == ($past(acc_is_cs) && $past(acc_ctl[AREA_MUX_BIT])))
        else $error("multiplex setting not applied");
    a_illegal_flag: assert property (ce && take && acc_illegal |=> // [RULE_07]
        acc_fault && !acc_go && state_reg == EBC_IDLE)
        else $error("illegal access not faulted");
    a_timeout_at: assert property (tmo_fire |-> busy_cnt == TMO_CHECK) // [RULE_08]
        else $error("timeout not at limit");
    a_irq_raise: assert property (ce && (flt_set & flt_mask_reg) != 2'h0 ##1 ce // [RULE_09]
        |=> bus_fault_irq)
        else $error("fault did not raise interrupt");
    a_enable_gate: assert property (ce && !flt_stat_reg[FLT_ILL_BIT] // [RULE_10]
        && !bus_fault_enable_reg[FLT_ILL_BIT] |=> !flt_stat_reg[FLT_ILL_BIT])
        else $error("illegal fault recorded while disabled");
    a_addr_capture: assert property (ce && flt_set != 2'h0 && flt_stat_reg == 2'h0 // [RULE_11]
        |=> bus_fault_addr_reg == $past(flt_addr[ADDR_CAP_LSB+:CAP_W]))
        else $error("fault address not captured");
    a_clear_status: assert property (ce && wr_clr && flt_set == 2'h0 |=> // [RULE_12]
        flt_stat_reg == 2'h0 && bus_fault_addr_reg == '0)
        else $error("status not cleared");

    c_normal: cover property (acc_go ##[1:20] (state_reg == EBC_BUSY && acc_done));
    c_illegal: cover property (ill_evt && bus_fault_enable_reg[FLT_ILL_BIT]);
    c_timeout: cover property (tmo_fire && bus_fault_enable_reg[FLT_TMO_BIT]);
    c_irq: cover property ($rose(bus_fault_irq));
endmodule

// [testbench/ebc_mem_model.sv]
// Purpose: Memory controller side, requests external accesses and ends them
// Assumes: Same clock as the block; requests launched just after an edge
// Notes: A negative latency never ends the access, so it hangs
`timescale 1ns/1ps
module ebc_mem_model (
    // Clock
    input wire logic hclk,
    // Block side
    input wire logic acc_go,
    input wire logic acc_fault,
    output logic acc_start,
    output logic [31:0] acc_addr,
    output logic acc_done
);
    initial begin
        acc_start = 1'b0;
        acc_addr = 32'h0;
        acc_done = 1'b0;
    end

    task automatic access(input logic [31:0] a, input int lat, output logic go,
        output logic flt);
        go = 1'b0;
        flt = 1'b0;
        @(posedge hclk);
        acc_start <= 1'b1;
        acc_addr <= a;
        @(posedge hclk);
        acc_start <= 1'b0;
        // Released address shows junk, never the last value
        acc_addr <= ~a;
        for (int i = 0; i < 4 && !(go || flt); i++) begin
            #1;
            go = acc_go;
            flt = acc_fault;
            if (!(go || flt)) @(posedge hclk);
        end
        if (go && lat >= 0) begin
            repeat (lat) @(posedge hclk);
            acc_done <= 1'b1;
            @(posedge hclk);
            acc_done <= 1'b0;
            // Idle cycle owed before the next start
            @(posedge hclk);
        end
    endtask
endmodule

// [testbench/ebc_top_tb.sv]
// Purpose: Self-checking bench for the area setup and bus fault block
// Assumes: Zero wait AHB-Lite slave, timeout shortened to LIM cycles
// Notes: Settings packed as {cs_sel, sdram, little, width, mux}
`timescale 1ns/1ps
module ebc_top_tb import ebc_pkg::*;;
    localparam int LIM = 16;
    typedef struct packed {
        logic [7:0] ofs;
        logic [31:0] val;
        logic [2:0] endc;
        logic [1:0] sw4;
        logic [31:0] addr;
        logic flt;
        logic [12:0] set;
    } ebc_row_t;
    // Widths stay off 32 on the multiplexed area, see row 1
    ebc_row_t rows [7] = '{
        '{8'h20, 32'h001, 3'h7, 2'h0, 32'hFF000000, 1'b0, 13'h0028},
        '{8'h3C, 32'h113, 3'h7, 2'h0, 32'hF8000010, 1'b0, 13'h1003},
        '{8'h2C, 32'h023, 3'h0, 2'h0, 32'hFC000000, 1'b0, 13'h010C},
        '{8'h28, 32'h011, 3'h0, 2'h0, 32'hFD000000, 1'b0, 13'h0082},
        '{8'h08, 32'h021, 3'h7, 2'h2, 32'h08000000, 1'b0, 13'h0014},
        '{8'h24, 32'h000, 3'h7, 2'h0, 32'hFE000000, 1'b1, 13'h0000},
        '{8'h24, 32'h000, 3'h7, 2'h0, 32'h40000000, 1'b1, 13'h0000}};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic ce = 1'b1;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, acc_start, acc_done, acc_go, acc_fault;
    logic acc_sdram_sel, acc_little_endian, acc_mux, bus_fault_irq, go, flt;
    logic [31:0] hrdata, acc_addr;
    logic [7:0] acc_cs_sel;
    logic [1:0] acc_width;
    logic [12:0] set_now;
    int fail_count = 0;
    int total_checks = 0;
    int n;

    assign set_now = {acc_cs_sel, acc_sdram_sel, acc_little_endian, acc_width, acc_mux};
    always #5 hclk = ~hclk;

    ebc_top #(.NUM_CS(8), .TIMEOUT_LIMIT(LIM)) dut (.hclk(hclk), .hresetn(hresetn),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .acc_start(acc_start), .acc_addr(acc_addr),
        .acc_done(acc_done), .acc_go(acc_go), .acc_fault(acc_fault),
        .acc_cs_sel(acc_cs_sel), .acc_sdram_sel(acc_sdram_sel),
        .acc_little_endian(acc_little_endian), .acc_width(acc_width), .acc_mux(acc_mux),
        .bus_fault_irq(bus_fault_irq));

    ebc_mem_model mem (.hclk(hclk), .acc_go(acc_go), .acc_fault(acc_fault),
        .acc_start(acc_start), .acc_addr(acc_addr), .acc_done(acc_done));

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && k < 8) begin
            k++;
            @(posedge hclk);
        end
        if (k >= 8) begin
            fail_count++;
            results();
        end
    endtask

    task automatic bus_rw(input logic wr, input logic [7:0] ofs, input logic [31:0] d,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wr ? d : ~d;
        wait_rdy();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] rd;
        bus_rw(1'b1, ofs, d, rd);
    endtask

    task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] rd;
        bus_rw(1'b0, ofs, 32'h0, rd);
        chk(rd, exp);
    endtask

    // Status lands one edge after its cause, irq one edge later
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge hclk);
        #1;
        chk({31'h0, bus_fault_irq}, {31'h0, exp});
    endtask

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(OFS_ENDIAN, 32'h7);
        rd_chk(OFS_FLT_EN, 32'h0);
        rd_chk(OFS_FLT_ADDR, 32'h0);
        rd_chk(8'hF0, 32'h0);
        wr(OFS_FLT_EN, 32'h3);
        wr(OFS_FLT_MASK, 32'h3);
        foreach (rows[i]) begin
            wr(OFS_ENDIAN, {29'h0, rows[i].endc});
            wr(OFS_SDRAM_MODE, {30'h0, rows[i].sw4});
            wr(rows[i].ofs, rows[i].val);
            mem.access(rows[i].addr, 3, go, flt);
            chk({31'h0, flt}, {31'h0, rows[i].flt});
            chk({31'h0, go}, {31'h0, !rows[i].flt});
            if (!rows[i].flt) chk({19'h0, set_now}, {19'h0, rows[i].set});
        end
        $display("table rows done");
        irq_chk(1'b1);
        rd_chk(OFS_FLT_STAT, 32'h1);
        rd_chk(OFS_FLT_ADDR, {16'h0, rows[5].addr[31:19], 3'h0});
        wr(OFS_FLT_MASK, 32'h0);
        irq_chk(1'b0);
        wr(OFS_FLT_MASK, 32'h3);
        irq_chk(1'b1);
        wr(OFS_FLT_CLR, 32'h1);
        irq_chk(1'b0);
        rd_chk(OFS_FLT_STAT, 32'h0);
        rd_chk(OFS_FLT_ADDR, 32'h0);
        $display("irq and clear done");
        wr(OFS_FLT_EN, 32'h2);
        mem.access(32'h40000000, 3, go, flt);
        irq_chk(1'b0);
        rd_chk(OFS_FLT_STAT, 32'h0);
        wr(OFS_FLT_EN, 32'h3);
        mem.access(32'h48000000, 3, go, flt);
        rd_chk(OFS_FLT_ADDR, {16'h0, 13'h0900, 3'h0});
        wr(OFS_FLT_STAT, 32'h1);
        rd_chk(OFS_FLT_STAT, 32'h0);
        $display("enable test done");
        // Executable areas keep swap clear, as CS0 does here
        mem.access(32'hFF000000, LIM - 1, go, flt);
        rd_chk(OFS_FLT_STAT, 32'h0);
        mem.access(32'hFF100000, -1, go, flt);
        n = 1;
        while (acc_fault !== 1'b1 && n < LIM + 8) begin
            @(posedge hclk);
            #1;
            n++;
        end
        chk(n, LIM + 2);
        irq_chk(1'b1);
        rd_chk(OFS_FLT_STAT, 32'h2);
        rd_chk(OFS_FLT_ADDR, {16'h0, 13'h1FE2, 3'h0});
        $display("timeout test done");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({30'h0, bus_fault_irq, acc_little_endian}, 32'h1);
        hresetn <= 1'b1;
        rd_chk(OFS_FLT_STAT, 32'h0);
        rd_chk(OFS_ENDIAN, 32'h7);
        // Frozen block ignores a write
        ce <= 1'b0;
        wr(OFS_ENDIAN, 32'h0);
        ce <= 1'b1;
        rd_chk(OFS_ENDIAN, 32'h7);
        $display("reset test done");
        results();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        results();
    end
endmodule
